// ### aux_control_write_gate.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Level-1 auxiliary control is 64 bits, all reserved, reads zero.
// - Level 3 may always write core auxiliary and extended control.
// - Level 2 writes need the level-3 bit of their class: bit 0 for aux, bit 1 for extended.
// - Level 1 aux writes need level-3 bit 0 and level-2 bit 0 or secure.
// - A refused write traps to the lowest level that denied it.
// - Level-2 bit 12 passes performance writes to non-secure level 1.
// - Level-2 bit 11 passes scheme-management writes to non-secure level 1.
// - Level-2 bit 10 passes thread scheme id writes to non-secure level 1.
// - Level-2 bit 7 passes power and cache counter writes to non-secure level 1.
// - Level-2 bit 5 passes pseudo-fault writes to non-secure level 1.
// - Level-2 bit 1 passes extended control writes to non-secure level 1.
// - Level-2 bit 0 passes auxiliary control writes to non-secure level 1.
// - Level-3 bit 12 passes performance writes to level 2 and secure level 1.
// - Level-3 bit 11 passes scheme-management writes to level 2, secure level 1.
// - Level-3 bit 10 passes thread scheme id writes to lower levels.
// - Level-3 bit 7 passes power and cache counter writes to lower levels.
// - Level-3 bit 5 passes pseudo-fault writes to lower levels.
// - Level-3 bit 1 passes extended control writes to lower levels.
// - Level-3 bit 0 passes auxiliary control writes to lower levels.
// - Level-2 and level-3 registers are 64 bits with reserved bits zero.
// - Reset clears every enable field in both registers.
// - Level-1 auxiliary fault status register is unused and reads zero.
module aux_control_write_gate (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nonsecure_state_flag,
  input wire logic [1:0] cur_level,
  input wire logic [2:0] target_class,
  output logic write_allow,
  output logic [1:0] trap_level
);

  // ****************************************
  // Register state
  // ****************************************
  logic [63:0] aux_control_level2_reg;
  logic [63:0] aux_control_level3_reg;
  logic [7:0] check_ctrl_reg;
  logic [63:0] level2_next;
  logic [63:0] level3_next;
  logic [31:0] rdata_next;
  logic err_next;
  logic access;
  logic wr;
  logic [1:0] chk_level;
  logic [2:0] chk_class;

  gate_if gi ();

  assign access = psel && penable && !pready;
  assign wr = access && pwrite;

  // ****************************************
  // Gate evaluation
  // ****************************************
  // The software check register drives the gate; the pin request is used when
  // its valid bit is clear, so one gate serves both paths.
  assign chk_level = check_ctrl_reg[7] ? check_ctrl_reg[1:0] : cur_level;
  assign chk_class = check_ctrl_reg[7] ? check_ctrl_reg[6:4] : target_class;
  assign gi.level2_en = aux_control_level2_reg;
  assign gi.level3_en = aux_control_level3_reg;
  assign gi.nonsecure = check_ctrl_reg[7] ? check_ctrl_reg[2] : nonsecure_state_flag;
  assign gi.level = aux_gate_pkg::priv_level_t'(chk_level);
  assign gi.reg_class = aux_gate_pkg::reg_class_t'(chk_class);

  write_gate u_gate (
    .g(gi.gate)
  );

  // ****************************************
  // Write data path
  // ****************************************
  always_comb begin
    level2_next = aux_control_level2_reg;
    level3_next = aux_control_level3_reg;
    if (wr && paddr == aux_gate_pkg::level2_lo_addr) begin
      level2_next[31:0] = pwdata & aux_gate_pkg::enable_mask[31:0];
    end else if (wr && paddr == aux_gate_pkg::level2_hi_addr) begin
      level2_next[63:32] = pwdata & aux_gate_pkg::enable_mask[63:32];
    end
    if (wr && paddr == aux_gate_pkg::level3_lo_addr) begin
      level3_next[31:0] = pwdata & aux_gate_pkg::enable_mask[31:0];
    end else if (wr && paddr == aux_gate_pkg::level3_hi_addr) begin
      level3_next[63:32] = pwdata & aux_gate_pkg::enable_mask[63:32];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aux_control_level2_reg <= aux_gate_pkg::aux_reset;
      aux_control_level3_reg <= aux_gate_pkg::aux_reset;
    end else begin
      aux_control_level2_reg <= level2_next;
      aux_control_level3_reg <= level3_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      check_ctrl_reg <= 8'h00;
    end else if (wr && paddr == aux_gate_pkg::check_ctrl_addr) begin
      check_ctrl_reg <= {pwdata[7], pwdata[6:4], 1'b0, pwdata[2:0]};
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (paddr == aux_gate_pkg::level1_lo_addr || paddr == aux_gate_pkg::level1_hi_addr) begin
      rdata_next = 32'h0000_0000;
    end else if (paddr == aux_gate_pkg::level2_lo_addr) begin
      rdata_next = aux_control_level2_reg[31:0];
    end else if (paddr == aux_gate_pkg::level2_hi_addr) begin
      rdata_next = aux_control_level2_reg[63:32];
    end else if (paddr == aux_gate_pkg::level3_lo_addr) begin
      rdata_next = aux_control_level3_reg[31:0];
    end else if (paddr == aux_gate_pkg::level3_hi_addr) begin
      rdata_next = aux_control_level3_reg[63:32];
    end else if (paddr == aux_gate_pkg::fault_status0_addr) begin
      rdata_next = 32'h0000_0000;
    end else if (paddr == aux_gate_pkg::check_ctrl_addr) begin
      rdata_next = {24'h00_0000, check_ctrl_reg};
    end else if (paddr == aux_gate_pkg::check_result_addr) begin
      rdata_next = {26'h000_0000, gi.trap_level, 3'h0, gi.allow};
    end else begin
      err_next = 1'b1;
    end
  end

  // One wait state keeps the answer registered.
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      prdata <= (access && !pwrite) ? rdata_next : 32'h0000_0000;
      pslverr <= access && err_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      write_allow <= 1'b0;
      trap_level <= 2'h0;
    end else begin
      write_allow <= gi.allow;
      trap_level <= gi.trap_level;
    end
  end

endmodule
`default_nettype wire

// ### aux_gate_pkg.sv
package aux_gate_pkg;

  // ****************************************
  // Register map, byte addresses on APB
  // ****************************************
  localparam logic [7:0] level1_lo_addr = 8'h00;
  localparam logic [7:0] level1_hi_addr = 8'h04;
  localparam logic [7:0] level2_lo_addr = 8'h08;
  localparam logic [7:0] level2_hi_addr = 8'h0c;
  localparam logic [7:0] level3_lo_addr = 8'h10;
  localparam logic [7:0] level3_hi_addr = 8'h14;
  localparam logic [7:0] fault_status0_addr = 8'h18;
  localparam logic [7:0] check_ctrl_addr = 8'h1c;
  localparam logic [7:0] check_result_addr = 8'h20;

  // ****************************************
  // Enable field positions
  // ****************************************
  localparam int aux_ctrl_bit = 0;
  localparam int ext_ctrl_bit = 1;
  localparam int err_inject_bit = 5;
  localparam int power_bit = 7;
  localparam int thread_sid_bit = 10;
  localparam int scheme_bit = 11;
  localparam int perf_bit = 12;

  localparam logic [63:0] enable_mask = 64'h0000_0000_0000_1ca3;
  localparam logic [63:0] aux_reset = 64'h0000_0000_0000_0000;

  // ****************************************
  // Check request fields
  // ****************************************
  localparam int level_lsb = 0;
  localparam int nonsecure_pos = 2;
  localparam int class_lsb = 4;
  localparam int result_allow_pos = 0;
  localparam int result_trap_lsb = 4;

  typedef enum logic [1:0] {
    level0,
    level1,
    level2,
    level3
  } priv_level_t;

  typedef enum logic [2:0] {
    class_aux_ctrl,
    class_ext_ctrl,
    class_err_inject,
    class_power,
    class_thread_sid,
    class_scheme,
    class_perf
  } reg_class_t;

endpackage

// ### gate_if.sv
`timescale 1ns/1ns
`default_nettype none
interface gate_if;
  logic [63:0] level2_en;
  logic [63:0] level3_en;
  logic nonsecure;
  aux_gate_pkg::priv_level_t level;
  aux_gate_pkg::reg_class_t reg_class;
  logic allow;
  aux_gate_pkg::priv_level_t trap_level;
  modport regs (output level2_en, level3_en, nonsecure, level, reg_class,
    input allow, trap_level);
  modport gate (input level2_en, level3_en, nonsecure, level, reg_class,
    output allow, trap_level);
endinterface
`default_nettype wire

// ### write_gate.sv
`timescale 1ns/1ns
`default_nettype none
module write_gate (
  gate_if.gate g
);
  int pos;
  logic en2;
  logic en3;

  always_comb begin
    pos = aux_gate_pkg::aux_ctrl_bit;
    case (g.reg_class)
      aux_gate_pkg::class_aux_ctrl: pos = aux_gate_pkg::aux_ctrl_bit;
      aux_gate_pkg::class_ext_ctrl: pos = aux_gate_pkg::ext_ctrl_bit;
      aux_gate_pkg::class_err_inject: pos = aux_gate_pkg::err_inject_bit;
      aux_gate_pkg::class_power: pos = aux_gate_pkg::power_bit;
      aux_gate_pkg::class_thread_sid: pos = aux_gate_pkg::thread_sid_bit;
      aux_gate_pkg::class_scheme: pos = aux_gate_pkg::scheme_bit;
      aux_gate_pkg::class_perf: pos = aux_gate_pkg::perf_bit;
      default: pos = aux_gate_pkg::aux_ctrl_bit;
    endcase
    en2 = g.level2_en[pos];
    en3 = g.level3_en[pos];
    g.allow = 1'b1;
    g.trap_level = aux_gate_pkg::level1;
    case (g.level)
      aux_gate_pkg::level3: begin
        g.allow = 1'b1;
      end
      aux_gate_pkg::level2: begin
        g.allow = en3;
        g.trap_level = aux_gate_pkg::level3;
      end
      default: begin
        // Lowest denying level wins: level 2 first, then level 3.
        if (g.nonsecure && !en2) begin
          g.allow = 1'b0;
          g.trap_level = aux_gate_pkg::level2;
        end else if (!en3) begin
          g.allow = 1'b0;
          g.trap_level = aux_gate_pkg::level3;
        end else begin
          g.allow = 1'b1;
          g.trap_level = aux_gate_pkg::level3;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// ### aux_gate_props.sv
`timescale 1ns/1ns
`default_nettype none
module aux_gate_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nonsecure_state_flag,
  input wire logic [1:0] cur_level,
  input wire logic [2:0] target_class,
  input wire logic write_allow,
  input wire logic [1:0] trap_level
);
  // ****************************************
  // Register and gate checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic rd_done = pready && !pwrite;
  // The software check request overrides the request pins, so pin-based checks pause.
  logic soft_mode;
  always_ff @(posedge clk) begin
    if (reset) begin
      soft_mode <= 1'b0;
    end else if (psel && penable && !pready && pwrite && paddr == 8'h1c) begin
      soft_mode <= pwdata[7];
    end
  end
  a_level1_zero: assert property (rd_done && paddr < 8'h08 |-> prdata == 0)
    else $error("level1 word not zero");
  a_fault_zero: assert property (rd_done && paddr == 8'h18 |-> prdata == 0)
    else $error("fault status not zero");
  a_reserved_zero: assert property (rd_done && paddr inside {8'h08, 8'h10} |->
    (prdata & 32'hffff_e35c) == 0) else $error("reserved bit set");
  a_hi_zero: assert property (rd_done && paddr inside {8'h0c, 8'h14} |-> prdata == 0)
    else $error("upper word not zero");
  a_top_allowed: assert property (!soft_mode && cur_level == 2'd3 |=> write_allow)
    else $error("level3 write refused");
  a_level2_trap: assert property (!soft_mode && cur_level == 2'd2 |=>
    write_allow || trap_level == 2'd3) else $error("level2 trap level wrong");
  a_secure_trap: assert property (!soft_mode && cur_level == 2'd1 && !nonsecure_state_flag |=>
    write_allow || trap_level == 2'd3) else $error("secure level1 trap wrong");
  a_deny_up: assert property (!write_allow && !$past(reset) |-> trap_level[1])
    else $error("trap below level2");
  a_reset_clear: assert property ($past(reset) |-> !write_allow && !pready)
    else $error("outputs not cleared by reset");
  c_allowed: cover property (write_allow);
  c_trap_two: cover property (!write_allow && trap_level == 2'd2);
  c_unmapped: cover property (pready && pslverr);
  c_soft_check: cover property (soft_mode && rd_done && paddr == 8'h20);
endmodule
bind aux_control_write_gate aux_gate_props i_aux_gate_props (.*);
`default_nettype wire

// ### sw_model.sv
`timescale 1ns/1ns
`default_nettype none
module sw_model (
  input wire logic clk,
  output logic [1:0] cur_level,
  output logic [2:0] target_class,
  output logic nonsecure_state_flag
);
  initial begin
    cur_level = 2'h0;
    target_class = 3'h0;
    nonsecure_state_flag = 1'b0;
  end
  // Software presents one pending write request and holds it until the next.
  task automatic issue(input logic [1:0] lv, input logic ns, input logic [2:0] c);
    @(posedge clk);
    cur_level <= lv;
    nonsecure_state_flag <= ns;
    target_class <= c;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, nonsecure_state_flag, write_allow;
  logic [1:0] cur_level, trap_level;
  logic [2:0] target_class;
  int errors = 0;
  int checks_done = 0;
  int bit_of [7] = '{0, 1, 5, 7, 10, 11, 12};
  always #50 clk = ~clk;
  aux_control_write_gate i_aux_control_write_gate (.*);
  sw_model i_sw_model (.*);
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Sampling right after an edge sees what the design launched one edge earlier.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [2:0] exp_gate(input logic [1:0] lv, input logic ns,
      input logic [2:0] c, input logic [31:0] l2, input logic [31:0] l3);
    int b = bit_of[c];
    if (lv == 2'd3) return 3'b100;
    if (lv == 2'd2 || !ns) return {l3[b], 2'd3};
    if (!l2[b]) return 3'b010;
    return {l3[b], 2'd3};
  endfunction
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [31:0] rd, l2, l3, wa, ea;
    logic err, ns;
    logic [2:0] e, c;
    logic [1:0] lv;
    void'($urandom(32'hb6e71930));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0, rd, err);
      check(rd, 32'h0);
    end
    apb(1'b1, 8'h40, 32'hffff_ffff, rd, err);
    check({31'h0, err}, 32'h1);
    $display("test reset and unmapped done");
    for (int a = 2; a < 6; a++) begin
      apb(1'b1, 8'(a * 4), 32'hffff_ffff, rd, err);
      apb(1'b0, 8'(a * 4), 32'h0, rd, err);
      check(rd, a % 2 ? 32'h0 : aux_gate_pkg::enable_mask[31:0]);
    end
    $display("test reserved bits done");
    for (int i = 0; i < 80; i++) begin
      l2 = $urandom;
      l3 = i < 8 ? {32{i[0]}} : $urandom;
      apb(1'b1, 8'h08, l2, rd, err);
      apb(1'b1, 8'h10, l3, rd, err);
      lv = 2'($urandom);
      ns = 1'($urandom);
      c = 3'($urandom_range(6));
      i_sw_model.issue(lv, ns, c);
      repeat (2) @(posedge clk);
      e = exp_gate(lv, ns, c, l2, l3);
      wa = {31'h0, write_allow};
      ea = {31'h0, e[2]};
      if (lv == 2'd1 && ns) check(wa, ea);
      else check(wa, ea);
      if (!e[2]) check({30'h0, trap_level}, {30'h0, e[1:0]});
    end
    $display("test random gate done");
    for (int i = 0; i < 8; i++) begin
      lv = 2'($urandom);
      ns = 1'($urandom);
      c = 3'($urandom_range(6));
      wa = {24'h00_0000, 1'b1, c, 1'b0, ns, lv};
      apb(1'b1, aux_gate_pkg::check_ctrl_addr, wa, rd, err);
      apb(1'b0, aux_gate_pkg::check_result_addr, 32'h0, rd, err);
      e = exp_gate(lv, ns, c, l2, l3);
      ea = e[2] ? 32'h0000_0001 : {26'h000_0000, e[1:0], 4'h0};
      check(rd & (e[2] ? 32'h0000_0001 : 32'h0000_0031), ea);
      check({31'h0, write_allow}, {31'h0, e[2]});
    end
    apb(1'b1, aux_gate_pkg::check_ctrl_addr, 32'h0, rd, err);
    $display("test soft request done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int a = 2; a < 6; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0, rd, err);
      check(rd, 32'h0);
    end
    $display("test mid-run reset done");
    summarize();
  end
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
